// ==== design/pfts_trace_status.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfts_trace_status
  import pfts_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire pfts_core_t core_in,
  input wire pfts_bus_t bus_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output pfts_pins_t pins_out
);
  pfts_state_t q;
  pfts_state_t d;
  logic sync_chg;
  logic attr;
  logic s_type_ok;

  // Fetch kinds that set a mark in the type slot; used by checks only
  assign s_type_ok = core_in.kind == FK_EXC || core_in.kind == FK_IND;

  always_comb begin
    d = q;
    // Trace-sync is a software bit; any edge must reach the queue bus
    sync_chg = q.ctrl_sync != q.sync_prev;
    d.sync_prev = q.ctrl_sync;
    if (sync_chg) begin
      d.sync_pend = 1'b1;
    end
    // Bus cycle marking; clear first so a new mark set below wins
    attr = bus_in.valid && bus_in.instr && (bus_in.indirect || q.mark_next);
    if (bus_in.valid) begin
      d.pins.address_type_bit = bus_in.instr;
      if (attr && bus_in.ext_miss) begin
        d.pins.cycle_type_bus = CT_IND_EXT;
      end else begin
        d.pins.cycle_type_bus = bus_in.code;
      end
      if (bus_in.instr) begin
        d.pins.wr_n = !(attr && !bus_in.ext_miss);
        d.mark_next = 1'b0;
      end else begin
        d.pins.wr_n = !bus_in.write;
      end
    end else begin
      d.pins.address_type_bit = 1'b0;
      d.pins.cycle_type_bus = CT_IDLE;
      d.pins.wr_n = 1'b1;
    end
    // History flushes saturate at two; 11 is kept for debug
    if (core_in.hist_flush > HS_MAX) begin
      d.pins.history_status_bus = HS_MAX;
    end else begin
      d.pins.history_status_bus = core_in.hist_flush;
    end
    // One report every clock
    if (core_in.debug_mode) begin
      d.pins.queue_status_bus = QS_NONE;
      d.pins.history_status_bus = HS_DEBUG;
      d.exit_pend = 1'b1;
      d.expect_flush = 1'b0;
    end else if (q.exit_pend) begin
      d.exit_pend = 1'b0;
      d.mark_next = 1'b1;
      if (q.sync_pend || sync_chg) begin
        d.pins.queue_status_bus = QS_SYNC;
        d.expect_flush = 1'b0;
      end else begin
        d.pins.queue_status_bus = QS_IND;
        d.expect_flush = 1'b1;
      end
      d.sync_pend = 1'b0;
    end else if (q.expect_flush) begin
      if (core_in.fetch_valid && core_in.kind == FK_BNT) begin
        d.pins.queue_status_bus = QS_BNT_FL;
        d.expect_flush = 1'b1;
      end else begin
        if (core_in.flush_count > QS_FLUSH_MAX) begin
          d.pins.queue_status_bus = QS_FLUSH_MAX;
        end else begin
          d.pins.queue_status_bus = core_in.flush_count;
        end
        d.expect_flush = 1'b0;
      end
    end else if (q.sync_pend) begin
      // Sync change takes the type slot; the fetch type is lost
      d.pins.queue_status_bus = QS_SYNC;
      d.sync_pend = sync_chg;
      d.mark_next = 1'b1;
    end else if (core_in.fetch_valid) begin
      case (core_in.kind)
        FK_SEQ: d.pins.queue_status_bus = QS_SEQ;
        FK_BNT: d.pins.queue_status_bus = QS_BNT;
        FK_EXC: d.pins.queue_status_bus = QS_EXC;
        FK_IND: d.pins.queue_status_bus = QS_IND;
        FK_DIR: d.pins.queue_status_bus = QS_DIR;
        default: d.pins.queue_status_bus = QS_NONE;
      endcase
      d.expect_flush = d.pins.queue_status_bus[2];
      if (core_in.kind == FK_EXC || core_in.kind == FK_IND) begin
        d.mark_next = 1'b1;
      end
    end else begin
      d.pins.queue_status_bus = QS_NONE;
    end
    // APB slave: answer one cycle after setup
    d.pready = psel_in && !penable_in && !q.pready;
    if (psel_in && !penable_in && !q.pready) begin
      d.pslverr = 1'b0;
      if (paddr_in == ADDR_CTRL) begin
        d.prdata = {31'h0, q.ctrl_sync};
      end else if (paddr_in == ADDR_STAT) begin
        d.prdata = {17'h0, q.exit_pend, q.expect_flush, q.sync_pend,
                    q.mark_next, q.pins};
      end else begin
        d.prdata = 32'h0;
        d.pslverr = 1'b1;
      end
    end else if (!q.pready) begin
      d.pslverr = 1'b0;
    end
    if (psel_in && penable_in && q.pready && pwrite_in && !q.pslverr &&
        paddr_in == ADDR_CTRL) begin
      d.ctrl_sync = pwdata_in[CTRL_SYNC_BIT];
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
      q.pins.wr_n <= 1'b1;
      q.ctrl_sync <= CTRL_SYNC_RESET;
      q.sync_prev <= CTRL_SYNC_RESET;
    end else begin
      q <= d;
    end
  end

  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
  assign pins_out = q.pins;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_debug_exit;
    core_in.debug_mode ##1 !core_in.debug_mode;
  endsequence

  sequence s_quiet_exit;
    (core_in.debug_mode && !q.sync_pend && q.ctrl_sync == q.sync_prev)
      ##1 (!core_in.debug_mode && q.ctrl_sync == q.sync_prev);
  endsequence

  a_debug_hold: assert property (
    core_in.debug_mode |=> pins_out.queue_status_bus == QS_NONE &&
      pins_out.history_status_bus == HS_DEBUG)
    else $error("debug mode status not 000/11");

  a_hist_not_debug: assert property (
    !core_in.debug_mode |=> pins_out.history_status_bus != HS_DEBUG)
    else $error("history code 11 outside debug");

  a_hist_count: assert property (
    !core_in.debug_mode && core_in.hist_flush <= HS_MAX
      |=> pins_out.history_status_bus == $past(core_in.hist_flush))
    else $error("history flush count wrong");

  a_flush_range: assert property (
    q.expect_flush && !q.exit_pend && !core_in.debug_mode &&
      !(core_in.fetch_valid && core_in.kind == FK_BNT)
      |=> pins_out.queue_status_bus <= QS_FLUSH_MAX)
    else $error("flush count above five");

  a_special_bnt: assert property (
    q.expect_flush && !q.exit_pend && !core_in.debug_mode &&
      core_in.fetch_valid && core_in.kind == FK_BNT
      |=> pins_out.queue_status_bus == QS_BNT_FL && q.expect_flush)
    else $error("not-taken in flush slot not 111");

  // Slots follow the priority of the report chain above
  sequence s_type_slot;
    !core_in.debug_mode && !q.exit_pend && !q.expect_flush && !q.sync_pend;
  endsequence

  sequence s_flush_slot;
    q.expect_flush && !q.exit_pend && !core_in.debug_mode &&
      !(core_in.fetch_valid && core_in.kind == FK_BNT);
  endsequence

  a_type_none: assert property (
    s_type_slot ##0 !core_in.fetch_valid
      |=> pins_out.queue_status_bus == QS_NONE)
    else $error("idle type slot not 000");

  a_type_seq: assert property (
    s_type_slot ##0 (core_in.fetch_valid && core_in.kind == FK_SEQ)
      |=> pins_out.queue_status_bus == QS_SEQ)
    else $error("sequential fetch not 001");

  a_type_bnt: assert property (
    s_type_slot ##0 (core_in.fetch_valid && core_in.kind == FK_BNT)
      |=> pins_out.queue_status_bus == QS_BNT)
    else $error("not-taken in type slot not 010");

  a_type_exc: assert property (
    s_type_slot ##0 (core_in.fetch_valid && core_in.kind == FK_EXC)
      |=> pins_out.queue_status_bus == QS_EXC && q.mark_next)
    else $error("exception not 100 with mark");

  a_type_dir: assert property (
    s_type_slot ##0 (core_in.fetch_valid && core_in.kind == FK_DIR)
      |=> pins_out.queue_status_bus == QS_DIR)
    else $error("direct taken not 110");

  a_type_ind: assert property (
    s_type_slot ##0 (core_in.fetch_valid && core_in.kind == FK_IND)
      |=> pins_out.queue_status_bus == QS_IND && q.mark_next)
    else $error("indirect not 101 with mark");

  a_flush_next: assert property (
    s_type_slot ##0 (core_in.fetch_valid && (core_in.kind == FK_EXC ||
      core_in.kind == FK_IND || core_in.kind == FK_DIR))
      |=> q.expect_flush)
    else $error("flush slot not opened after taken");

  a_type_again: assert property (
    s_type_slot ##0 (!core_in.fetch_valid || core_in.kind == FK_NONE ||
      core_in.kind == FK_SEQ || core_in.kind == FK_BNT)
      |=> !q.expect_flush)
    else $error("flush slot opened after plain type");

  a_flush_count: assert property (
    s_flush_slot ##0 core_in.flush_count <= QS_FLUSH_MAX
      |=> pins_out.queue_status_bus == $past(core_in.flush_count))
    else $error("flush count not reported");

  a_flush_sat: assert property (
    s_flush_slot ##0 core_in.flush_count > QS_FLUSH_MAX
      |=> pins_out.queue_status_bus == QS_FLUSH_MAX)
    else $error("flush count not saturated");

  a_flush_once: assert property (
    s_flush_slot |=> !q.expect_flush)
    else $error("flush slot not closed");

  a_sync_slot: assert property (
    q.sync_pend && !q.expect_flush && !q.exit_pend &&
      !core_in.debug_mode
      |=> pins_out.queue_status_bus == QS_SYNC && q.mark_next)
    else $error("pending sync change not 011");

  a_sync_keep: assert property (
    q.ctrl_sync != q.sync_prev && !(q.exit_pend && !core_in.debug_mode)
      |=> q.sync_pend)
    else $error("sync change not held pending");

  a_addr_type: assert property (
    bus_in.valid |=> pins_out.address_type_bit == $past(bus_in.instr))
    else $error("address type bit wrong");

  a_ct_code: assert property (
    bus_in.valid && !(bus_in.instr && bus_in.ext_miss &&
      (bus_in.indirect || q.mark_next))
      |=> pins_out.cycle_type_bus == $past(bus_in.code))
    else $error("cycle type not passed through");

  a_bus_idle: assert property (
    !bus_in.valid |=> pins_out.cycle_type_bus == CT_IDLE &&
      !pins_out.address_type_bit && pins_out.wr_n)
    else $error("idle bus pins not quiet");

  a_ext_no_wr: assert property (
    bus_in.valid && bus_in.instr && bus_in.ext_miss &&
      (bus_in.indirect || q.mark_next)
      |=> pins_out.wr_n && pins_out.cycle_type_bus == CT_IND_EXT)
    else $error("external attribute used wr marker");

  a_wr_plain: assert property (
    bus_in.valid && bus_in.instr && !bus_in.indirect && !q.mark_next
      |=> pins_out.wr_n)
    else $error("plain fetch marked on wr");

  a_data_wr: assert property (
    bus_in.valid && !bus_in.instr |=> pins_out.wr_n == !$past(bus_in.write))
    else $error("data cycle direction wrong");

  a_mark_clear: assert property (
    bus_in.valid && bus_in.instr && !core_in.debug_mode && !q.exit_pend &&
      !q.sync_pend && !(core_in.fetch_valid && s_type_ok)
      |=> !q.mark_next)
    else $error("mark not cleared by fetch");

  a_apb_err: assert property (
    psel_in && !penable_in && !q.pready && paddr_in != ADDR_CTRL &&
      paddr_in != ADDR_STAT
      |=> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not refused");

  a_apb_write: assert property (
    psel_in && penable_in && q.pready && pwrite_in && !q.pslverr &&
      paddr_in == ADDR_CTRL
      |=> q.ctrl_sync == $past(pwdata_in[CTRL_SYNC_BIT]))
    else $error("control write lost");

  a_exit_sync: assert property (
    (core_in.debug_mode && q.sync_pend) ##1 !core_in.debug_mode
      |=> pins_out.queue_status_bus == QS_SYNC)
    else $error("sync change not first after debug");

  a_exit_ind: assert property (
    s_quiet_exit |=> pins_out.queue_status_bus == QS_IND)
    else $error("first report after debug not 101");

  a_exit_mark: assert property (
    s_debug_exit |=> q.mark_next)
    else $error("first fetch after debug not marked");

  a_ct_external: assert property (
    bus_in.valid && bus_in.instr && bus_in.indirect && bus_in.ext_miss
      |=> pins_out.cycle_type_bus == CT_IND_EXT && pins_out.address_type_bit)
    else $error("external indirect fetch not 0001");

  a_wr_marker: assert property (
    bus_in.valid && bus_in.instr && !bus_in.ext_miss &&
      (bus_in.indirect || q.mark_next)
      |=> !pins_out.wr_n && pins_out.address_type_bit)
    else $error("internal indirect fetch not marked on wr");

  a_apb_ready: assert property (
    psel_in && !penable_in && !q.pready
      |=> pready_out ##1 !pready_out)
    else $error("apb ready not one cycle after setup");
endmodule // pfts_trace_status
`default_nettype wire

// ==== inc/pfts_pkg.sv ====
// Notes on behaviour
// - Queue status carries type or flush count
// - Codes 000-011 are type, then type again
// - Exception 100, direct 110, 111: flush follows
// - Indirect and context changers use 101, flush follows
// - Flush codes 000-101 count zero to five
// - Only 111 may replace expected flush count
// - History bus 00/01/10 counts buffer flushes
// - History code 11 only means debug mode
// - Debug mode holds 000 and 11
// - Sync change in debug reported first on exit
// - Otherwise first report after debug is 101
// - First fetch after debug carries trace attribute
// - Address type bit shows instruction or data
// - Write/read low marks indirect internal show fetch
// - Cycle type bus gives bus cycle type
// - Indirect external miss uses cycle type 0001
// - Attributed fetches drive address type high
package pfts_pkg;
  localparam logic [2:0] QS_NONE = 3'h0;
  localparam logic [2:0] QS_SEQ = 3'h1;
  localparam logic [2:0] QS_BNT = 3'h2;
  localparam logic [2:0] QS_SYNC = 3'h3;
  localparam logic [2:0] QS_EXC = 3'h4;
  localparam logic [2:0] QS_IND = 3'h5;
  localparam logic [2:0] QS_DIR = 3'h6;
  localparam logic [2:0] QS_BNT_FL = 3'h7;
  localparam logic [2:0] QS_FLUSH_MAX = 3'h5;
  localparam logic [1:0] HS_MAX = 2'h2;
  localparam logic [1:0] HS_DEBUG = 2'h3;
  localparam logic [3:0] CT_IDLE = 4'h0;
  localparam logic [3:0] CT_IND_EXT = 4'h1;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam int CTRL_SYNC_BIT = 0;
  localparam logic CTRL_SYNC_RESET = 1'b0;

  typedef enum logic [2:0] {
    FK_NONE, FK_SEQ, FK_BNT, FK_EXC, FK_IND, FK_DIR
  } pfts_fetch_kind_t;

  typedef struct packed {
    logic fetch_valid;
    pfts_fetch_kind_t kind;
    logic [2:0] flush_count;
    logic [1:0] hist_flush;
    logic debug_mode;
  } pfts_core_t;

  typedef struct packed {
    logic valid;
    logic instr;
    logic write;
    logic ext_miss;
    logic indirect;
    logic [3:0] code;
  } pfts_bus_t;

  typedef struct packed {
    logic [2:0] queue_status_bus;
    logic [1:0] history_status_bus;
    logic address_type_bit;
    logic wr_n;
    logic [3:0] cycle_type_bus;
  } pfts_pins_t;

  typedef struct packed {
    pfts_pins_t pins;
    logic expect_flush;
    logic sync_pend;
    logic exit_pend;
    logic mark_next;
    logic sync_prev;
    logic ctrl_sync;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pfts_state_t;
endpackage

// ==== verification/pfts_capture_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfts_capture_model
  import pfts_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire pfts_pins_t pins_in,
  output logic [15:0] attr_cnt_out,
  output logic [15:0] dbg_cnt_out
);
  // Samples every clock; counts debug history codes and attributed fetch cycles
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      attr_cnt_out <= 16'h0000;
      dbg_cnt_out <= 16'h0000;
    end else begin
      if (pins_in.history_status_bus == 2'h3) begin
        dbg_cnt_out <= dbg_cnt_out + 16'h0001;
      end
      if (pins_in.address_type_bit && (!pins_in.wr_n ||
          pins_in.cycle_type_bus == 4'h1)) begin
        attr_cnt_out <= attr_cnt_out + 16'h0001;
      end
    end
  end
endmodule // pfts_capture_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) chk(32'(a), 32'(b))
module tb_top import pfts_pkg::*; ;
  logic core_clk_in, rstn_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic pready_out, pslverr_out, chk_q, chk_bus, ef, mk;
  pfts_core_t core_in, c;
  pfts_bus_t bus_in, b;
  pfts_pins_t pins_out, exp;
  logic [15:0] lfsr;
  int error_cnt, check_count, attr_exp, dbg_exp;
  logic [15:0] attr_cnt, dbg_cnt;
  pfts_trace_status dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .core_in(core_in),
    .bus_in(bus_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pins_out(pins_out));
  pfts_capture_model cap (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .pins_in(pins_out), .attr_cnt_out(attr_cnt), .dbg_cnt_out(dbg_cnt));
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [2:0] qs_of(input pfts_core_t x, input logic e);
    if (x.debug_mode) return 3'h0;
    if (e) begin
      if (x.fetch_valid && x.kind == FK_BNT) return 3'h7;
      return (x.flush_count > 3'h5) ? 3'h5 : x.flush_count;
    end
    if (!x.fetch_valid) return 3'h0;
    case (x.kind)
      FK_SEQ: return 3'h1;
      FK_BNT: return 3'h2;
      FK_EXC: return 3'h4;
      FK_IND: return 3'h5;
      FK_DIR: return 3'h6;
      default: return 3'h0;
    endcase
  endfunction
  task automatic step(input pfts_core_t x, input pfts_bus_t y,
                      input logic ov, input logic [2:0] oq);
    logic ind;
    logic [2:0] q;
    core_in <= x;
    bus_in <= y;
    @(posedge core_clk_in);
    q = ov ? oq : qs_of(x, ef);
    ind = y.instr && (y.indirect || mk);
    exp.queue_status_bus = q;
    exp.history_status_bus = x.debug_mode ? 2'h3 :
      ((x.hist_flush > 2'h2) ? 2'h2 : x.hist_flush);
    exp.address_type_bit = y.instr;
    exp.wr_n = !(y.write || (ind && !y.ext_miss));
    exp.cycle_type_bus = (ind && y.ext_miss) ? 4'h1 : y.code;
    if (y.valid && y.instr && (!exp.wr_n || exp.cycle_type_bus == 4'h1))
      attr_exp++;
    if (y.valid && y.instr) mk = 1'b0;
    if (!ef && !x.debug_mode && q inside {3'h3, 3'h4, 3'h5}) mk = 1'b1;
    ef = !x.debug_mode && (ef ? (q == 3'h7) : q[2]);
    chk_bus = y.valid;
    chk_q = 1'b1;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] er, input logic ee);
    int n;
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    if (pready_out !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
    if (!w) `CHK(prdata_out, er);
    `CHK(pslverr_out, ee);
  endtask
  always @(negedge core_clk_in) begin
    if (rstn_in && core_in.debug_mode) dbg_exp++;
    if (chk_q) begin
      `CHK(pins_out.queue_status_bus, exp.queue_status_bus);
      `CHK(pins_out.history_status_bus, exp.history_status_bus);
      if (chk_bus) begin
        `CHK(pins_out.address_type_bit, exp.address_type_bit);
        `CHK(pins_out.wr_n, exp.wr_n);
        `CHK(pins_out.cycle_type_bus, exp.cycle_type_bus);
      end
      chk_q = 1'b0;
    end
  end
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  initial begin
    repeat (50000) @(posedge core_clk_in);
    error_cnt++;
    end_of_test();
  end
  initial begin
    {rstn_in, psel_in, penable_in, pwrite_in, chk_q, chk_bus, ef, mk} = '0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0000_0000;
    core_in = '0;
    bus_in = '0;
    lfsr = 16'h0D56;
    error_cnt = 0;
    check_count = 0;
    attr_exp = 0;
    dbg_exp = 0;
    repeat (4) @(posedge core_clk_in);
    `CHK(pins_out, 11'h010);
    rstn_in <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      c = '0;
      b = '0;
      c.debug_mode = 1'b1;
      repeat (3) step(c, b, 1'b0, 3'h0);
      if (k == 1) begin
        apb(1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h1, 32'h0, 1'b0);
        apb(1'b0, ADDR_CTRL, 32'h0, 32'h1, 1'b0);
        apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
      end
      c.debug_mode = 1'b0;
      step(c, b, 1'b1, (k == 1) ? 3'h3 : 3'h5);
      b.valid = 1'b1;
      b.instr = 1'b1;
      b.code = 4'h4;
      step(c, b, 1'b0, 3'h0);
    end
    for (int i = 0; i < 400; i++) begin
      repeat (5) lfsr = nxt(lfsr);
      c = '0;
      b = '0;
      c.fetch_valid = lfsr[0];
      c.kind = pfts_fetch_kind_t'(lfsr[3:1] % 3'h6);
      c.flush_count = lfsr[6:4];
      c.hist_flush = lfsr[8:7];
      if (ef && c.kind != FK_BNT) c.fetch_valid = 1'b0;
      b.valid = lfsr[9];
      b.instr = lfsr[10];
      b.write = !lfsr[10] && lfsr[11];
      b.indirect = lfsr[10] && lfsr[12];
      b.ext_miss = lfsr[13];
      b.code = lfsr[15:12];
      step(c, b, 1'b0, 3'h0);
    end
    @(posedge core_clk_in);
    @(negedge core_clk_in);
    `CHK(attr_cnt, attr_exp);
    `CHK(dbg_cnt, dbg_exp);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
